/* inc/ampseq_pkg.sv */
// Constants for the amplifier power-up and shutdown sequencer.
// Assumes a 40 MHz host clock; every wait is a whole count of cycles.
package ampseq_pkg;

  // ----------------------------------------------------------------
  // Clock and minimum waits
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 40;
  localparam int T_PWR_HOLD_US   = 100;
  localparam int T_RST_REL_US    = 13_500;
  localparam int T_TRIM_US       = 50_000;
  localparam int T_SD_BASE_US    = 1_000;
  localparam int T_LOSS_US       = 2_000;
  localparam int T_FIRST_TRIM_US = 240_000;
  localparam int T_RST_LOW_US    = 2;
  localparam int PWM_UNIT_US     = 1;

  // Integer MHz, so microsecond counts are exact and never short
  localparam int CYC_PWR_HOLD   = T_PWR_HOLD_US * CLK_MHZ;
  localparam int CYC_RST_REL    = T_RST_REL_US * CLK_MHZ;
  localparam int CYC_TRIM       = T_TRIM_US * CLK_MHZ;
  localparam int CYC_SD_BASE    = T_SD_BASE_US * CLK_MHZ;
  localparam int CYC_LOSS       = T_LOSS_US * CLK_MHZ;
  localparam int CYC_FIRST_TRIM = T_FIRST_TRIM_US * CLK_MHZ;
  localparam int CYC_RST_LOW    = T_RST_LOW_US * CLK_MHZ;
  // 1.3 times one PWM time unit, rounded up
  localparam int CYC_PWM_13     = (PWM_UNIT_US * CLK_MHZ * 13 + 9) / 10;
  localparam int I2C_QTR_CYC    = 100;

  // ----------------------------------------------------------------
  // Amplifier registers and values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SHUTDOWN = 8'h05;
  localparam logic [7:0] REG_PWM_TIME = 8'h1a;
  localparam logic [7:0] REG_OSC_TRIM = 8'h1b;
  localparam logic [7:0] VAL_TRIM     = 8'h00;
  localparam logic [7:0] VAL_SD_ENTER = 8'h40;
  localparam logic [7:0] VAL_SD_EXIT  = 8'h00;
  localparam logic [7:0] PWM_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // Host-side registers
  // ----------------------------------------------------------------
  localparam logic [2:0] A_CMD     = 3'h0;
  localparam logic [2:0] A_STATUS  = 3'h1;
  localparam logic [2:0] A_UADDR   = 3'h2;
  localparam logic [2:0] A_UDATA   = 3'h3;
  localparam logic [2:0] A_PWMTIME = 3'h4;

  localparam int CB_INIT  = 0;
  localparam int CB_ENTER = 1;
  localparam int CB_EXIT  = 2;
  localparam int CB_PDOWN = 3;
  localparam int CB_LOSS  = 4;
  localparam int CB_UWR   = 5;

  localparam int SB_BUSY    = 0;
  localparam int SB_RUN     = 1;
  localparam int SB_SHUT    = 2;
  localparam int SB_WIN     = 3;
  localparam int SB_NACK    = 4;
  localparam int SB_REFUSE  = 5;
  localparam int SB_POWERED = 6;

endpackage

/* inc/ampseq_i2c_if.sv */
// Write-request link between the sequencer and its bus engine.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface ampseq_i2c_if;
  logic       req;
  logic [7:0] reg_addr;
  logic [7:0] data;
  logic       hold_low;
  logic       busy;
  logic       done;
  logic       nack;
  modport master (output req, reg_addr, data, hold_low,
                  input busy, done, nack);
  modport engine (input req, reg_addr, data, hold_low,
                  output busy, done, nack);
endinterface

/* rtl/ampseq_timer.sv */
// Down-counting wait timer.
// Assumes a load count of at least one cycle.
`timescale 1ns/1ps
module ampseq_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_r <= count;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign done = (cnt_r == '0);
endmodule // ampseq_timer

/* rtl/ampseq_i2c.sv */
// Write-only bus engine: start, device address, register, data, stop.
// Assumes open-drain lines with pull-ups; honours clock stretching.
`timescale 1ns/1ps
module ampseq_i2c #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter int         QTR      = ampseq_pkg::I2C_QTR_CYC
) (
  input  wire logic   clk,
  input  wire logic   arst_n,
  input  wire logic   ce,
  ampseq_i2c_if.engine bus,
  input  wire logic   scl_level,
  output logic        scl_oe_n,
  input  wire logic   sda_level,
  output logic        sda_oe_n
);
  typedef enum logic [1:0] {e_idle, e_start, e_bits, e_stop}
    ampseq_eng_type;

  ampseq_eng_type st_r;
  logic [15:0]    div_r;
  logic [1:0]     ph_r;
  logic [4:0]     idx_r;
  logic [26:0]    sh_r;
  logic           scl_r, sda_r, acc_r, done_r, nack_r;

  // Released clock held low by the far side stalls the divider
  wire stretch  = scl_r && !scl_level;
  wire tick     = (div_r == 16'h0000) && !stretch;
  wire ack_slot = (idx_r == 5'h08) || (idx_r == 5'h11) ||
                  (idx_r == 5'h1a);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= e_idle;  div_r <= '0;  ph_r <= '0;  idx_r <= '0;
      sh_r <= '0;  scl_r <= 1'b0;  sda_r <= 1'b0;
      acc_r <= 1'b0;  done_r <= 1'b0;  nack_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (st_r != e_idle && !stretch) begin
        div_r <= tick ? 16'(QTR - 1) : div_r - 1'b1;
      end
      if (tick && st_r != e_idle) begin
        ph_r <= ph_r + 1'b1;
      end
      unique case (st_r)
        e_idle: begin
          scl_r <= !bus.hold_low;
          sda_r <= !bus.hold_low;
          if (bus.req) begin
            sh_r  <= {DEV_ADDR, 1'b0, 1'b1, bus.reg_addr, 1'b1,
                      bus.data, 1'b1};
            st_r  <= e_start;  ph_r <= '0;  acc_r <= 1'b0;
            div_r <= 16'(QTR - 1);
            scl_r <= 1'b1;  sda_r <= 1'b1;
          end
        end
        e_start: if (tick) begin
          if (ph_r == 2'd0) begin
            sda_r <= 1'b0;
          end else begin
            scl_r <= 1'b0;  st_r <= e_bits;
            ph_r  <= '0;  idx_r <= '0;
          end
        end
        e_bits: if (tick) begin
          unique case (ph_r)
            2'd0: sda_r <= sh_r[26];
            2'd1: scl_r <= 1'b1;
            2'd2: if (ack_slot && sda_level) acc_r <= 1'b1;
            2'd3: begin
              scl_r <= 1'b0;
              sh_r  <= {sh_r[25:0], 1'b0};
              idx_r <= idx_r + 1'b1;
              if (idx_r == 5'h1a) st_r <= e_stop;
            end
          endcase
        end
        e_stop: if (tick) begin
          unique case (ph_r)
            2'd0: sda_r <= 1'b0;
            2'd1: scl_r <= 1'b1;
            default: begin
              sda_r  <= 1'b1;  st_r <= e_idle;
              done_r <= 1'b1;  nack_r <= acc_r;
            end
          endcase
        end
      endcase
    end
  end

  assign scl_oe_n = scl_r;
  assign sda_oe_n = sda_r;
  assign bus.busy = (st_r != e_idle);
  assign bus.done = done_r;
  assign bus.nack = nack_r;
endmodule // ampseq_i2c

/* rtl/ampseq_top.sv */
// Host sequencer: power-up, trim, shutdown and power-down of the amp.
// Assumes software on the plain register port; one 40 MHz clock.
`timescale 1ns/1ps
module ampseq_top #(
  parameter logic [6:0] I2C_DEV_ADDR   = 7'h2a, // Arbitrary address
  parameter int         I2C_QTR        = ampseq_pkg::I2C_QTR_CYC,
  parameter int         CYC_RST_REL    = ampseq_pkg::CYC_RST_REL,
  parameter int         CYC_TRIM       = ampseq_pkg::CYC_TRIM,
  parameter int         CYC_SD_BASE    = ampseq_pkg::CYC_SD_BASE,
  parameter int         CYC_LOSS       = ampseq_pkg::CYC_LOSS,
  parameter int         CYC_FIRST_TRIM = ampseq_pkg::CYC_FIRST_TRIM,
  parameter int         CYC_PWM_13     = ampseq_pkg::CYC_PWM_13
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  output logic            amp_reset_n,
  output logic            amp_power_down_n,
  input  wire logic       scl_level,
  output logic            scl_drive,
  output logic            scl_oe_n,
  input  wire logic       sda_level,
  output logic            sda_drive,
  output logic            sda_oe_n
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    s_off, s_pwr, s_rstw, s_trim_wr, s_trim_w, s_cfg, s_exit_wr,
    s_exit_w, s_run, s_enter_wr, s_enter_w, s_shut, s_loss, s_rst_low
  } ampseq_state_type;

  ampseq_state_type state_r, state_nxt;
  logic        rst_pin_r, pdn_r, first_r, pd_pend_r;
  logic        usr_pend_r, sent_r, nack_st_r, refuse_st_r;
  logic [7:0]  uaddr_r, udata_r, pwm_r, rd_data_r, status, rd_mux;
  logic        tmr_load, tmr_done, win_done;
  logic [31:0] tmr_val;

  ampseq_i2c_if bus ();

  // ----------------------------------------------------------------
  // Command decode and legality
  // ----------------------------------------------------------------
  wire       cmd_wr  = wr_en && (addr == ampseq_pkg::A_CMD);
  wire [7:0] cmd     = cmd_wr ? wr_data : 8'h00;
  wire       c_init  = cmd[ampseq_pkg::CB_INIT];
  wire       c_enter = cmd[ampseq_pkg::CB_ENTER];
  wire       c_exit  = cmd[ampseq_pkg::CB_EXIT];
  wire       c_pdown = cmd[ampseq_pkg::CB_PDOWN];
  wire       c_loss  = cmd[ampseq_pkg::CB_LOSS];
  wire       c_uwr   = cmd[ampseq_pkg::CB_UWR];
  wire [7:0] clr     = (wr_en && addr == ampseq_pkg::A_STATUS) ?
                       wr_data : 8'h00;

  wire st_sd    = (state_r == s_cfg) || (state_r == s_shut);
  wire stable   = st_sd || (state_r == s_run);
  wire op_idle  = !usr_pend_r && !sent_r;
  wire wr_state = (state_r == s_trim_wr) || (state_r == s_exit_wr) ||
                  (state_r == s_enter_wr);
  // Shutdown and trim registers only move through the sequences
  wire uaddr_ok = (uaddr_r != ampseq_pkg::REG_SHUTDOWN) &&
                  (uaddr_r != ampseq_pkg::REG_OSC_TRIM);
  wire init_ok  = (state_r == s_off);
  wire exit_ok  = st_sd && op_idle && win_done;
  wire enter_ok = (state_r == s_run) && op_idle;
  wire pd_ok    = stable && op_idle;
  wire loss_ok  = (state_r != s_off) && (state_r != s_loss) &&
                  (state_r != s_rst_low);
  wire uwr_ok   = stable && !usr_pend_r && uaddr_ok;
  wire take_uwr = c_uwr && uwr_ok && !c_loss;
  wire take_loss = c_loss && loss_ok;
  wire refuse   = (c_init && !init_ok) || (c_enter && !enter_ok) ||
                  (c_exit && !exit_ok) || (c_pdown && !pd_ok) ||
                  (c_loss && !loss_ok) || (c_uwr && !uwr_ok);

  // ----------------------------------------------------------------
  // Wait lengths from the PWM timing shadow
  // ----------------------------------------------------------------
  wire [31:0] pwm_scaled = 32'(pwm_r) * 32'(CYC_PWM_13);
  wire [31:0] wait_sd    = 32'(CYC_SD_BASE) + pwm_scaled;
  wire [31:0] wait_win   = 32'(CYC_FIRST_TRIM) + pwm_scaled;
  wire        win_load   = (state_r == s_trim_wr) && bus.done &&
                           first_r;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_val   = 32'h0000_0000;
    unique case (state_r)
      s_off: if (c_init && !c_loss) begin
        state_nxt = s_pwr;
        tmr_load  = 1'b1;
        tmr_val   = 32'(ampseq_pkg::CYC_PWR_HOLD);
      end
      s_pwr: if (tmr_done) begin
        state_nxt = s_rstw;
        tmr_load  = 1'b1;
        tmr_val   = 32'(CYC_RST_REL);
      end
      s_rstw: if (tmr_done) begin
        state_nxt = s_trim_wr;
      end
      s_trim_wr: if (bus.done) begin
        state_nxt = s_trim_w;
        tmr_load  = 1'b1;
        tmr_val   = 32'(CYC_TRIM);
      end
      s_trim_w: if (tmr_done) begin
        state_nxt = s_cfg;
      end
      s_cfg, s_shut: begin
        if (c_exit && exit_ok) begin
          state_nxt = s_exit_wr;
        end else if (c_pdown && pd_ok) begin
          state_nxt = s_rst_low;
          tmr_load  = 1'b1;
          tmr_val   = 32'(ampseq_pkg::CYC_RST_LOW);
        end
      end
      s_exit_wr: if (bus.done) begin
        state_nxt = s_exit_w;
        tmr_load  = 1'b1;
        tmr_val   = wait_sd;
      end
      s_exit_w: if (tmr_done) begin
        state_nxt = s_run;
      end
      s_run: if ((c_enter && enter_ok) || (c_pdown && pd_ok)) begin
        state_nxt = s_enter_wr;
      end
      s_enter_wr: if (bus.done) begin
        state_nxt = s_enter_w;
        tmr_load  = 1'b1;
        tmr_val   = wait_sd;
      end
      s_enter_w: if (tmr_done) begin
        if (pd_pend_r) begin
          state_nxt = s_rst_low;
          tmr_load  = 1'b1;
          tmr_val   = 32'(ampseq_pkg::CYC_RST_LOW);
        end else begin
          state_nxt = s_shut;
        end
      end
      s_loss: if (tmr_done) begin
        state_nxt = s_rst_low;
        tmr_load  = 1'b1;
        tmr_val   = 32'(ampseq_pkg::CYC_RST_LOW);
      end
      s_rst_low: if (tmr_done) begin
        state_nxt = s_off;
      end
      default: state_nxt = s_off;
    endcase
    if (take_loss) begin
      state_nxt = s_loss;
      tmr_load  = 1'b1;
      tmr_val   = 32'(CYC_LOSS);
    end
  end

  // Pin levels follow the next state so they change with it
  wire rst_nxt = (state_nxt != s_off) && (state_nxt != s_pwr) &&
                 (state_nxt != s_rst_low);
  wire pdn_nxt = (state_nxt == s_rst_low) ? pdn_r :
                 ((state_nxt != s_off) &&
                  (state_nxt != s_loss));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= s_off;
      rst_pin_r <= 1'b0;
      pdn_r     <= 1'b0;
      first_r   <= 1'b1;
      pd_pend_r <= 1'b0;
    end else if (ce) begin
      state_r   <= state_nxt;
      rst_pin_r <= rst_nxt;
      pdn_r     <= pdn_nxt;
      if (win_load) first_r <= 1'b0;
      if (take_loss || state_nxt == s_rst_low) begin
        pd_pend_r <= 1'b0;
      end else if (state_r == s_run && c_pdown && pd_ok) begin
        pd_pend_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus write requests
  // ----------------------------------------------------------------
  wire is_trim  = (state_r == s_trim_wr);
  wire is_exit  = (state_r == s_exit_wr);
  wire is_enter = (state_r == s_enter_wr);

  assign bus.req      = !sent_r && !bus.busy &&
                        (wr_state || (stable && usr_pend_r));
  assign bus.reg_addr = is_trim  ? ampseq_pkg::REG_OSC_TRIM :
                        wr_state ? ampseq_pkg::REG_SHUTDOWN : uaddr_r;
  assign bus.data     = is_trim  ? ampseq_pkg::VAL_TRIM :
                        is_exit  ? ampseq_pkg::VAL_SD_EXIT :
                        is_enter ? ampseq_pkg::VAL_SD_ENTER :
                        udata_r;
  assign bus.hold_low = (state_r == s_off);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sent_r      <= 1'b0;
      usr_pend_r  <= 1'b0;
      uaddr_r     <= 8'h00;
      udata_r     <= 8'h00;
      pwm_r       <= ampseq_pkg::PWM_RESET;
      nack_st_r   <= 1'b0;
      refuse_st_r <= 1'b0;
      rd_data_r   <= 8'h00;
    end else if (ce) begin
      if (bus.done) begin
        sent_r <= 1'b0;
      end else if (bus.req) begin
        sent_r <= 1'b1;
      end
      if (take_uwr) begin
        usr_pend_r <= 1'b1;
      end else if (take_loss || (bus.done && stable)) begin
        usr_pend_r <= 1'b0;
      end
      if (wr_en && addr == ampseq_pkg::A_UADDR) uaddr_r <= wr_data;
      if (wr_en && addr == ampseq_pkg::A_UDATA) udata_r <= wr_data;
      if (take_uwr && uaddr_r == ampseq_pkg::REG_PWM_TIME) begin
        pwm_r <= udata_r;
      end
      // Set wins over a clear in the same cycle
      nack_st_r   <= (bus.done && bus.nack) ||
                     (nack_st_r && !clr[ampseq_pkg::SB_NACK]);
      refuse_st_r <= refuse ||
                     (refuse_st_r && !clr[ampseq_pkg::SB_REFUSE]);
      rd_data_r   <= rd_en ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Timers and bus engine
  // ----------------------------------------------------------------
  ampseq_timer #(.W(32)) u_wait (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .load   (tmr_load),
    .count  (tmr_val),
    .done   (tmr_done)
  );

  ampseq_timer #(.W(32)) u_window (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .load   (win_load),
    .count  (wait_win),
    .done   (win_done)
  );

  ampseq_i2c #(.DEV_ADDR(I2C_DEV_ADDR), .QTR(I2C_QTR)) u_i2c (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .bus       (bus),
    .scl_level (scl_level),
    .scl_oe_n  (scl_oe_n),
    .sda_level (sda_level),
    .sda_oe_n  (sda_oe_n)
  );

  // ----------------------------------------------------------------
  // Status and read back
  // ----------------------------------------------------------------
  assign status[ampseq_pkg::SB_BUSY]    = !(stable && op_idle);
  assign status[ampseq_pkg::SB_RUN]     = (state_r == s_run);
  assign status[ampseq_pkg::SB_SHUT]    = st_sd;
  assign status[ampseq_pkg::SB_WIN]     = win_done;
  assign status[ampseq_pkg::SB_NACK]    = nack_st_r;
  assign status[ampseq_pkg::SB_REFUSE]  = refuse_st_r;
  assign status[ampseq_pkg::SB_POWERED] = rst_pin_r;
  assign status[7]                      = 1'b0;

  assign rd_mux =
    (addr == ampseq_pkg::A_STATUS)  ? status  :
    (addr == ampseq_pkg::A_UADDR)   ? uaddr_r :
    (addr == ampseq_pkg::A_UDATA)   ? udata_r :
    (addr == ampseq_pkg::A_PWMTIME) ? pwm_r   : 8'h00;

  assign rd_data          = rd_data_r;
  assign amp_reset_n      = rst_pin_r;
  assign amp_power_down_n = pdn_r;
  assign scl_drive        = 1'b0;
  assign sda_drive        = 1'b0;
endmodule // ampseq_top

/* dv/ampseq_properties.sv */
// Concurrent checks on the sequencer's amplifier pins and bus lines.
// Assumes binding into ampseq_top; a low ce only lengthens waits.
`timescale 1ns/1ps
module ampseq_properties #(
  parameter int CYC_RST_REL = 50,
  parameter int CYC_LOSS    = 30
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       ce,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       amp_reset_n,
  input wire logic       amp_power_down_n,
  input wire logic       scl_drive,
  input wire logic       scl_oe_n,
  input wire logic       sda_drive,
  input wire logic       sda_oe_n
);
  // ------------------------------------------------------------
  // Interval counters
  // ------------------------------------------------------------
  int   hold_r, rel_r, pdn_r, rst_r;
  logic cmd;
  assign cmd = ce && wr_en && addr == ampseq_pkg::A_CMD;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {hold_r, rel_r, pdn_r, rst_r} <= '0;
    end else begin
      hold_r <= (amp_power_down_n && !amp_reset_n) ? hold_r + 1 : 0;
      rel_r  <= amp_reset_n ? rel_r + 1 : 0;
      pdn_r  <= (!amp_power_down_n && amp_reset_n) ? pdn_r + 1 : 0;
      rst_r  <= amp_reset_n ? 0 : rst_r + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_rst_pins_low: assert property (
    $rose(arst_n) |-> !amp_reset_n && !amp_power_down_n && !sda_oe_n)
    else $error("pins not low after reset");
  a_drive_zero: assert property (
    scl_drive == 1'b0 && sda_drive == 1'b0) else $error("line driven high");
  a_init_pins: assert property (
    cmd && wr_data == 8'h01 && !amp_reset_n && !amp_power_down_n &&
    !sda_oe_n && !scl_oe_n |=> amp_power_down_n && !amp_reset_n ##1
    sda_oe_n && scl_oe_n) else $error("init pins wrong");
  a_rst_hold: assert property (
    $rose(amp_reset_n) |-> hold_r + 1 >= ampseq_pkg::CYC_PWR_HOLD)
    else $error("reset released early");
  a_start_after_rel: assert property (
    $fell(sda_oe_n) && scl_oe_n && amp_reset_n |-> rel_r + 1 >= CYC_RST_REL)
    else $error("bus start too soon");
  a_loss_prompt: assert property (
    cmd && wr_data[ampseq_pkg::CB_LOSS] && amp_reset_n && amp_power_down_n
    |=> !amp_power_down_n && amp_reset_n) else $error("loss not prompt");
  a_loss_hold: assert property (
    $fell(amp_reset_n) && !amp_power_down_n |-> pdn_r + 1 >= CYC_LOSS)
    else $error("reset after loss too soon");
  a_lines_after_rst: assert property (
    $fell(sda_oe_n) && !scl_oe_n && !amp_reset_n |->
    rst_r + 1 >= ampseq_pkg::CYC_RST_LOW) else $error("lines low too soon");
endmodule // ampseq_properties

bind ampseq_top ampseq_properties #(.CYC_RST_REL(CYC_RST_REL),
  .CYC_LOSS(CYC_LOSS)) u_props (.clk(clk), .arst_n(arst_n), .ce(ce),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .amp_reset_n(amp_reset_n),
  .amp_power_down_n(amp_power_down_n), .scl_drive(scl_drive),
  .scl_oe_n(scl_oe_n), .sda_drive(sda_drive), .sda_oe_n(sda_oe_n));

/* dv/ampseq_amp_model.sv */
// Amplifier bus model: acknowledges each byte, keeps the last write.
// Assumes pulled-up lines resolved by the bench.
`timescale 1ns/1ps
module ampseq_amp_model #(
  parameter realtime WIN_NS = 5000.0
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic       sda_pull,
  output logic [7:0] last_reg,
  output logic [7:0] last_data,
  output int         n_wr,
  output logic       early_exit
);
  logic [7:0] sh;
  int         bits = 0;
  int         bytes = 0;
  logic       trimmed = 1'b0;
  realtime    t_trim;
  initial begin
    sda_pull = 1'b0;
    n_wr = 0;
    early_exit = 1'b0;
  end
  // Start condition
  always @(negedge sda) if (scl) begin
    bits = 0;
    bytes = 0;
  end
  always @(posedge scl) if (!sda_pull) begin
    sh = {sh[6:0], sda};
    bits++;
  end
  always @(negedge scl) begin
    if (sda_pull) sda_pull = 1'b0;
    else if (bits == 8) begin
      bits = 0;
      bytes++;
      sda_pull = 1'b1;
      if (bytes == 2) last_reg = sh;
      if (bytes == 3) begin
        last_data = sh;
        n_wr++;
        if (last_reg == 8'h1b && !trimmed) begin
          trimmed = 1'b1;
          t_trim = $realtime;
        end
        if (last_reg == 8'h05 && sh == 8'h00 && trimmed &&
            $realtime - t_trim < WIN_NS) early_exit = 1'b1;
      end
    end
  end
endmodule // ampseq_amp_model

/* dv/ampseq_bench.sv */
// Self-checking bench for the amplifier sequencer.
// Assumes shortened waits and an always-acknowledging amplifier.
`timescale 1ns/1ps
module ampseq_bench;
  localparam int REL = 50, TRIM = 60, SDB = 20, LOSS = 30, WIN = 200;
  logic       clk = 1'b0, arst_n = 1'b0, ce = 1'b1;
  logic       wr_en = 1'b0, rd_en = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00, rd_data, lreg, ldat;
  logic       amp_reset_n, amp_power_down_n, scl_oe_n, sda_oe_n;
  logic       pull, early, scl, sda;
  int         n_errors = 0, checks = 0, nwr, cyc = 0, t0;
  assign scl = scl_oe_n;
  assign sda = sda_oe_n & !pull;
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  ampseq_top #(.I2C_QTR(4), .CYC_RST_REL(REL), .CYC_TRIM(TRIM),
    .CYC_SD_BASE(SDB), .CYC_LOSS(LOSS), .CYC_FIRST_TRIM(WIN),
    .CYC_PWM_13(1)) dut (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .amp_reset_n(amp_reset_n), .amp_power_down_n(amp_power_down_n),
    .scl_level(scl), .scl_drive(), .scl_oe_n(scl_oe_n), .sda_level(sda),
    .sda_drive(), .sda_oe_n(sda_oe_n));
  ampseq_amp_model #(.WIN_NS(WIN * 25.0)) amp (.scl(scl), .sda(sda),
    .sda_pull(pull), .last_reg(lreg), .last_data(ldat), .n_wr(nwr),
    .early_exit(early));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail_to();
    n_errors++;
    $display("CHECK FAILED %0t wait ran out", $time);
    close_out();
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk) wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk) rd_en <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
  endtask
  task automatic rds(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] s;
    rd(a, s);
    chk(s, exp);
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] s;
    for (int i = 0; i < 30000; i++) begin
      rd(ampseq_pkg::A_STATUS, s);
      if ((s & m) === v) return;
    end
    fail_to();
  endtask
  task automatic wait_wr(input int n);
    for (int i = 0; i < 3000; i++) begin
      if (nwr == n) begin
        t0 = cyc;
        return;
      end
      @(posedge clk);
    end
    fail_to();
  endtask
  task automatic wait_off();
    for (int i = 0; i < 3000; i++) begin
      if ({amp_reset_n, amp_power_down_n, scl_oe_n, sda_oe_n} === 4'h0) return;
      @(posedge clk);
    end
    fail_to();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_power_up(input int n, input logic [7:0] st);
    wr(ampseq_pkg::A_CMD, 8'h01);
    #1 chk({5'h0, amp_power_down_n, amp_reset_n, sda_oe_n}, 8'h05);
    poll(8'h05, 8'h04);
    chk(lreg, 8'h1b);
    chk(ldat, 8'h00);
    chk(nwr[7:0], n[7:0]);
    rds(ampseq_pkg::A_STATUS, st);
  endtask
  task automatic t_config();
    wr(ampseq_pkg::A_CMD, 8'h04);
    rds(ampseq_pkg::A_STATUS, 8'h64);
    wr(ampseq_pkg::A_STATUS, 8'h20);
    poll(8'h08, 8'h08);
    rds(ampseq_pkg::A_STATUS, 8'h4c);
    wr(ampseq_pkg::A_UADDR, 8'h1a);
    wr(ampseq_pkg::A_UDATA, 8'h02);
    wr(ampseq_pkg::A_CMD, 8'h20);
    wait_wr(2);
    chk(lreg, 8'h1a);
    poll(8'h01, 8'h00);
    rds(ampseq_pkg::A_PWMTIME, 8'h02);
    wr(ampseq_pkg::A_UADDR, 8'h05);
    wr(ampseq_pkg::A_CMD, 8'h20);
    rds(ampseq_pkg::A_STATUS, 8'h6c);
    wr(ampseq_pkg::A_STATUS, 8'h20);
  endtask
  task automatic t_shut(input int n, input logic [7:0] cmd);
    wr(ampseq_pkg::A_CMD, cmd);
    wait_wr(n);
    chk(lreg, 8'h05);
    chk(ldat, cmd[1] ? 8'h40 : 8'h00);
    poll(8'h07, cmd[1] ? 8'h04 : 8'h02);
    chk({7'h0, cyc - t0 >= SDB + 2}, 8'h01);
    rds(ampseq_pkg::A_STATUS, cmd[1] ? 8'h4c : 8'h4a);
  endtask
  task automatic t_pdown(input int n);
    wr(ampseq_pkg::A_CMD, 8'h08);
    wait_wr(n);
    chk(ldat, 8'h40);
    wait_off();
    chk({7'h0, amp_power_down_n}, 8'h00);
  endtask
  task automatic t_loss();
    t0 = cyc;
    wr(ampseq_pkg::A_CMD, 8'h10);
    #1 chk({6'h0, amp_power_down_n, amp_reset_n}, 8'h01);
    // Clock enable low must freeze the loss wait
    ce <= 1'b0;
    repeat (200) @(posedge clk);
    chk({6'h0, amp_power_down_n, amp_reset_n}, 8'h01);
    ce <= 1'b1;
    wait_off();
    chk({7'h0, cyc - t0 >= LOSS + 280}, 8'h01);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({4'h0, amp_reset_n, amp_power_down_n, sda_oe_n, scl_oe_n},
        8'h00);
    rds(ampseq_pkg::A_STATUS, 8'h09);
    t_power_up(1, 8'h44);
    t_config();
    t_shut(3, 8'h04);
    t_shut(4, 8'h02);
    t_shut(5, 8'h04);
    t_pdown(6);
    t_power_up(7, 8'h4c);
    t_shut(8, 8'h04);
    t_loss();
    chk({7'h0, early}, 8'h00);
    close_out();
  end
endmodule // ampseq_bench
